// ### pkg/tmr_pkg.sv
// shared constants, register map and decode helpers of the three-channel timer core
package tmr_pkg;
   localparam int NCH = 3; // channels in the unit
   localparam int CW = 16; // counter and general register width

   // register map, byte addresses on a 16-bit word bus
   localparam logic [7:0] ADDR_GLOBAL = 8'h30; // hi: run control, lo: sync select
   localparam logic [3:0] OFS_CTRL_IO = 4'h0; // hi: control, lo: pin io control
   localparam logic [3:0] OFS_IE_FLAGS = 4'h2; // hi: interrupt enable, lo: status flags
   localparam logic [3:0] OFS_CNT = 4'h4; // channel counter
   localparam logic [3:0] OFS_GRA = 4'h6; // general register a
   localparam logic [3:0] OFS_GRB = 4'h8; // general register b
   localparam logic [3:0] OFS_GRC = 4'ha; // general register c, channel 0 only
   localparam logic [3:0] OFS_GRD = 4'hc; // general register d, channel 0 only

   // status flag positions
   localparam int FLAG_A = 0;
   localparam int FLAG_B = 1;
   localparam int FLAG_C = 2;
   localparam int FLAG_D = 3;

   // pin io control fields
   localparam int IO_CAP_A = 0; // register a captures on pin a rising edge
   localparam int IO_CAP_B = 1; // register b captures on pin b rising edge
   localparam int IO_CAP_C = 2; // channel 0 register c captures on pin a while CTRL_BUF_A is clear
   localparam int IO_INIT_A = 4; // initial level of pin a
   localparam int IO_INIT_B = 5; // initial level of pin b
   localparam int IO_TOGGLE = 6; // 1: toggle on match, 0: drive inverse of initial

   // control fields
   localparam int CTRL_CLR_LSB = 0; // two-bit counter clear source
   localparam int CTRL_BUF_A = 2; // channel 0: c buffers a
   localparam int CTRL_BUF_B = 3; // channel 0: d buffers b
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_A = 2'h1;
   localparam logic [1:0] CLR_B = 2'h2;
   localparam logic [1:0] CLR_SYNC = 2'h3;

   // reset values
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] GR_RST = 16'hffff;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // writable bit masks, reserved bits read zero
   localparam logic [7:0] RUN_MASK = 8'h07;
   localparam logic [7:0] SYNC_MASK = 8'h07;
   localparam logic [3:0] FLAG_MASK_CH0 = 4'hf;
   localparam logic [3:0] FLAG_MASK_CH12 = 4'h3;
   localparam logic [7:0] IO_MASK_CH0 = 8'h77;
   localparam logic [7:0] IO_MASK_CH12 = 8'h73;
   localparam logic [7:0] CTRL_MASK_CH0 = 8'h0f;
   localparam logic [7:0] CTRL_MASK_CH12 = 8'h03;

   // host sequencer states
   typedef enum logic [1:0] {
      HS_IDLE = 2'b01,
      HS_WAIT = 2'b10
   } tmr_host_state_type;

   // true for counter and general registers, which take only whole words
   function automatic logic tmr_is_word_reg(input logic [7:0] addr);
      logic [3:0] ofs;
      ofs = {addr[3:1], 1'b0};
      tmr_is_word_reg = (addr[7:6] == 2'b00) && (addr[5:4] != 2'b11) &&
                        (ofs >= OFS_CNT) && (ofs <= OFS_GRD);
   endfunction
endpackage

// ### pkg/tmr_bus_if.sv
// register bus between the bus master and the timer core
`timescale 1ns/1ps
`default_nettype none
interface tmr_bus_if;
   logic [7:0] addr; // byte address, bit 0 ignored
   logic wr; // one-cycle write strobe
   logic rd; // one-cycle read strobe
   logic [1:0] be; // lane enables, [1] = bits 15:8
   logic [15:0] wdata; // write data
   logic [15:0] rdata; // read data, valid with ack
   logic ack; // one-cycle answer
   modport dev(input addr, input wr, input rd, input be, input wdata, output rdata, output ack);
   modport host(output addr, output wr, output rd, output be, output wdata, input rdata,
                input ack);
endinterface
`default_nettype wire

// ### verilog/tmr_core_dev.sv
// device end: counters, general registers, status flags and pin logic of three channels
`timescale 1ns/1ps
`default_nettype none
module tmr_core_dev (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic COUNT_TICK,
   input wire logic [2:0][1:0] PIN_IN,
   tmr_bus_if.dev BUS,
   output logic [2:0][1:0] PIN_OUT,
   output logic [2:0][1:0] PIN_OE,
   output logic [2:0] IRQ
);
   // every flip-flop of the core
   typedef struct packed {
      logic [2:0][15:0] cnt; // channel counters
      logic [2:0][15:0] gra; // general registers a
      logic [2:0][15:0] grb; // general registers b
      logic [15:0] grc; // channel 0 register c
      logic [15:0] grd; // channel 0 register d
      logic [2:0][7:0] io; // pin io control
      logic [2:0][7:0] ctrl; // clear source and buffer mode
      logic [2:0][7:0] ie; // interrupt enables
      logic [2:0][3:0] flag; // status flags
      logic [2:0][3:0] armed; // flag seen as 1 by a read
      logic [2:0] run; // run bits
      logic [2:0] sync; // lockstep bits
      logic [2:0][1:0] pin_o; // pin output level
      logic [2:0][1:0] pin_oe; // pin drive enable
      logic [2:0][1:0] pin_prev; // last pin sample for edge detect
      logic [2:0] irq; // interrupt requests
      logic [15:0] rdata; // read data
      logic ack; // bus answer
   } tmr_dev_state_type;

   tmr_dev_state_type s_ff; // registered state
   tmr_dev_state_type nxt_s; // next state
   logic [1:0] chi; // addressed channel
   logic [3:0] ofs; // word offset inside the channel
   logic glob; // global word addressed
   logic chsel; // valid channel addressed
   logic wr_hi; // upper lane written
   logic wr_lo; // lower lane written
   logic wr_word; // whole word written
   logic rd_lo; // lower lane read
   logic [2:0] tick; // counting enable per channel
   logic [2:0][1:0] rise; // pin rising edges
   logic [2:0][3:0] ev; // flag events
   logic [2:0] capb; // capture into register b
   logic [2:0] cap_a_ev; // capture into register a
   logic [2:0] own_clr; // clear from channel's own source
   logic sync_clr; // some synced channel cleared itself
   logic [3:0] clr; // flags cleared by this write
   logic [1:0] csrc; // decoded clear source
   logic [3:0] fmask; // flag mask of the channel
   logic [15:0] rmux; // read mux result

   assign PIN_OUT = s_ff.pin_o;
   assign PIN_OE = s_ff.pin_oe;
   assign IRQ = s_ff.irq;
   assign BUS.rdata = s_ff.rdata;
   assign BUS.ack = s_ff.ack;

   // whole next-state function
   always_comb begin
      nxt_s = s_ff;
      nxt_s.ack = BUS.rd | BUS.wr;
      chi = BUS.addr[5:4];
      ofs = {BUS.addr[3:1], 1'b0};
      glob = (BUS.addr[7:1] == tmr_pkg::ADDR_GLOBAL[7:1]);
      chsel = (BUS.addr[7:6] == 2'b00) && (chi != 2'b11);
      wr_hi = BUS.wr & BUS.be[1];
      wr_lo = BUS.wr & BUS.be[0];
      // byte strobes on word registers are dropped, not half-written
      wr_word = BUS.wr & (&BUS.be);
      rd_lo = BUS.rd & BUS.be[0];
      rmux = 16'h0000;
      clr = 4'h0;
      csrc = tmr_pkg::CLR_NONE;
      fmask = 4'h0;
      // events and own clears per channel
      for (int c = 0; c < tmr_pkg::NCH; c++) begin
         tick[c] = COUNT_TICK & s_ff.run[c];
         rise[c] = PIN_IN[c] & ~s_ff.pin_prev[c];
         cap_a_ev[c] = s_ff.io[c][tmr_pkg::IO_CAP_A] & rise[c][0];
         capb[c] = s_ff.io[c][tmr_pkg::IO_CAP_B] & rise[c][1];
         ev[c] = 4'h0;
         // a: compare or capture
         ev[c][tmr_pkg::FLAG_A] = cap_a_ev[c] | (!s_ff.io[c][tmr_pkg::IO_CAP_A] && tick[c] &&
                                  s_ff.cnt[c] == s_ff.gra[c]);
         // b: flag only on compare
         ev[c][tmr_pkg::FLAG_B] = !s_ff.io[c][tmr_pkg::IO_CAP_B] && tick[c] &&
                                  s_ff.cnt[c] == s_ff.grb[c];
         csrc = s_ff.ctrl[c][tmr_pkg::CTRL_CLR_LSB +: 2];
         own_clr[c] = (csrc == tmr_pkg::CLR_A && ev[c][tmr_pkg::FLAG_A]) ||
                      (csrc == tmr_pkg::CLR_B && (ev[c][tmr_pkg::FLAG_B] | capb[c]));
      end
      // c and d exist on channel 0 only and fall silent while buffering
      ev[0][tmr_pkg::FLAG_C] = !s_ff.ctrl[0][tmr_pkg::CTRL_BUF_A] &&
                               (s_ff.io[0][tmr_pkg::IO_CAP_C] ? rise[0][0] :
                               (tick[0] && s_ff.cnt[0] == s_ff.grc));
      ev[0][tmr_pkg::FLAG_D] = !s_ff.ctrl[0][tmr_pkg::CTRL_BUF_B] && tick[0] &&
                               s_ff.cnt[0] == s_ff.grd;
      sync_clr = |(own_clr & s_ff.sync);

      // per-channel register update
      for (int c = 0; c < tmr_pkg::NCH; c++) begin
         fmask = (c == 0) ? tmr_pkg::FLAG_MASK_CH0 : tmr_pkg::FLAG_MASK_CH12;
         csrc = s_ff.ctrl[c][tmr_pkg::CTRL_CLR_LSB +: 2];
         // counter: bus write, then clear, then count
         if (wr_word && chsel && ofs == tmr_pkg::OFS_CNT &&
             (chi == 2'(c) || (s_ff.sync[c] && s_ff.sync[chi]))) begin
            nxt_s.cnt[c] = BUS.wdata;
         end else if (own_clr[c] || (s_ff.sync[c] && csrc == tmr_pkg::CLR_SYNC &&
                      sync_clr)) begin
            nxt_s.cnt[c] = tmr_pkg::CNT_RST;
         end else if (tick[c]) begin
            nxt_s.cnt[c] = s_ff.cnt[c] + 16'h0001; // wraps to zero
         end
         // general register writes, events below override them
         if (wr_word && chsel && chi == 2'(c)) begin
            if (ofs == tmr_pkg::OFS_GRA) nxt_s.gra[c] = BUS.wdata;
            if (ofs == tmr_pkg::OFS_GRB) nxt_s.grb[c] = BUS.wdata;
            if (c == 0 && ofs == tmr_pkg::OFS_GRC) nxt_s.grc = BUS.wdata;
            if (c == 0 && ofs == tmr_pkg::OFS_GRD) nxt_s.grd = BUS.wdata;
         end
         // captures load the counter value
         if (cap_a_ev[c]) nxt_s.gra[c] = s_ff.cnt[c];
         if (capb[c]) nxt_s.grb[c] = s_ff.cnt[c];
         // byte registers
         if (wr_hi && chsel && chi == 2'(c) && ofs == tmr_pkg::OFS_CTRL_IO) begin
            nxt_s.ctrl[c] = BUS.wdata[15:8] &
                            ((c == 0) ? tmr_pkg::CTRL_MASK_CH0 : tmr_pkg::CTRL_MASK_CH12);
         end
         if (wr_lo && chsel && chi == 2'(c) && ofs == tmr_pkg::OFS_CTRL_IO) begin
            nxt_s.io[c] = BUS.wdata[7:0] &
                          ((c == 0) ? tmr_pkg::IO_MASK_CH0 : tmr_pkg::IO_MASK_CH12);
         end
         if (wr_hi && chsel && chi == 2'(c) && ofs == tmr_pkg::OFS_IE_FLAGS) begin
            nxt_s.ie[c] = {4'h0, BUS.wdata[11:8] & fmask};
         end
         // flag clear needs a prior read of 1; a same-cycle event still sets
         clr = 4'h0;
         if (wr_lo && chsel && chi == 2'(c) && ofs == tmr_pkg::OFS_IE_FLAGS) begin
            clr = ~BUS.wdata[3:0] & s_ff.armed[c];
         end
         nxt_s.flag[c] = ((s_ff.flag[c] & ~clr) | ev[c]) & fmask;
         nxt_s.armed[c] = (s_ff.armed[c] & ~clr) & s_ff.flag[c];
         if (rd_lo && chsel && chi == 2'(c) && ofs == tmr_pkg::OFS_IE_FLAGS) begin
            nxt_s.armed[c] = (s_ff.flag[c] & ~clr) | nxt_s.armed[c];
         end
         // pin a drives unless capturing into a, pin b unless capturing into b
         nxt_s.pin_oe[c] = ~{s_ff.io[c][tmr_pkg::IO_CAP_B], s_ff.io[c][tmr_pkg::IO_CAP_A]};
         // halted counter makes no match, so the pin holds its level
         if (!s_ff.io[c][tmr_pkg::IO_CAP_A] && ev[c][tmr_pkg::FLAG_A]) begin
            nxt_s.pin_o[c][0] = s_ff.io[c][tmr_pkg::IO_TOGGLE] ? ~s_ff.pin_o[c][0] :
                                ~s_ff.io[c][tmr_pkg::IO_INIT_A];
         end
         if (ev[c][tmr_pkg::FLAG_B]) begin
            nxt_s.pin_o[c][1] = s_ff.io[c][tmr_pkg::IO_TOGGLE] ? ~s_ff.pin_o[c][1] :
                                ~s_ff.io[c][tmr_pkg::IO_INIT_B];
         end
         // new io setting while stopped shows its initial level at once
         if (wr_lo && chsel && chi == 2'(c) && ofs == tmr_pkg::OFS_CTRL_IO &&
             !s_ff.run[c]) begin
            nxt_s.pin_o[c] = {BUS.wdata[tmr_pkg::IO_INIT_B], BUS.wdata[tmr_pkg::IO_INIT_A]};
         end
         nxt_s.irq[c] = |(nxt_s.flag[c] & s_ff.ie[c][3:0]);
      end
      nxt_s.pin_prev = PIN_IN;

      // channel 0 buffer pairs: c with a, d with b
      if (s_ff.ctrl[0][tmr_pkg::CTRL_BUF_A]) begin
         if (cap_a_ev[0]) nxt_s.grc = s_ff.gra[0];
         else if (ev[0][tmr_pkg::FLAG_A]) nxt_s.gra[0] = s_ff.grc;
      end
      if (s_ff.ctrl[0][tmr_pkg::CTRL_BUF_B]) begin
         if (capb[0]) nxt_s.grd = s_ff.grb[0];
         else if (ev[0][tmr_pkg::FLAG_B]) nxt_s.grb[0] = s_ff.grd;
      end
      // unbuffered c captures the counter itself, else its flag would have no value behind it
      if (!s_ff.ctrl[0][tmr_pkg::CTRL_BUF_A] && s_ff.io[0][tmr_pkg::IO_CAP_C] &&
          rise[0][0]) begin
         nxt_s.grc = s_ff.cnt[0];
      end

      // global byte registers, reserved bits forced to zero
      if (wr_hi && glob) nxt_s.run = BUS.wdata[10:8] & tmr_pkg::RUN_MASK[2:0];
      if (wr_lo && glob) nxt_s.sync = BUS.wdata[2:0] & tmr_pkg::SYNC_MASK[2:0];

      // read mux, unmapped reads answer zero
      if (glob) begin
         rmux = {5'h00, s_ff.run, 5'h00, s_ff.sync};
      end else if (chsel) begin
         unique case (ofs)
            tmr_pkg::OFS_CTRL_IO: rmux = {s_ff.ctrl[chi], s_ff.io[chi]};
            tmr_pkg::OFS_IE_FLAGS: rmux = {s_ff.ie[chi], 4'h0, s_ff.flag[chi]};
            tmr_pkg::OFS_CNT: rmux = s_ff.cnt[chi];
            tmr_pkg::OFS_GRA: rmux = s_ff.gra[chi];
            tmr_pkg::OFS_GRB: rmux = s_ff.grb[chi];
            tmr_pkg::OFS_GRC: rmux = (chi == 2'b00) ? s_ff.grc : 16'h0000;
            tmr_pkg::OFS_GRD: rmux = (chi == 2'b00) ? s_ff.grd : 16'h0000;
            default: rmux = 16'h0000;
         endcase
      end
      if (BUS.rd) nxt_s.rdata = rmux;
   end

   // state register with synchronous reset
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         s_ff <= '0;
         for (int c = 0; c < tmr_pkg::NCH; c++) begin
            s_ff.cnt[c] <= tmr_pkg::CNT_RST;
            s_ff.gra[c] <= tmr_pkg::GR_RST;
            s_ff.grb[c] <= tmr_pkg::GR_RST;
            s_ff.pin_oe[c] <= 2'b11;
         end
         s_ff.grc <= tmr_pkg::GR_RST;
         s_ff.grd <= tmr_pkg::GR_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule
`default_nettype wire

// ### verilog/tmr_core_host.sv
// master end: turns user requests into single register bus cycles
`timescale 1ns/1ps
`default_nettype none
module tmr_core_host (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic USR_REQ,
   input wire logic USR_WRITE,
   input wire logic [7:0] USR_ADDR,
   input wire logic [1:0] USR_BE,
   input wire logic [15:0] USR_WDATA,
   output logic USR_READY,
   output logic USR_DONE,
   output logic [15:0] USR_RDATA,
   tmr_bus_if.host BUS
);
   // every flip-flop of the master
   typedef struct packed {
      tmr_pkg::tmr_host_state_type st; // sequencer state
      logic [7:0] addr; // bus address
      logic wr; // write strobe
      logic rd; // read strobe
      logic [1:0] be; // lane enables
      logic [15:0] wdata; // write data
      logic done; // transfer finished pulse
      logic [15:0] rdata; // captured read data
      logic ready; // idle and taking requests
   } tmr_host_s_type;

   tmr_host_s_type s_ff; // registered state
   tmr_host_s_type nxt_s; // next state
   logic [15:0] wd; // write data after masking

   assign BUS.addr = s_ff.addr;
   assign BUS.wr = s_ff.wr;
   assign BUS.rd = s_ff.rd;
   assign BUS.be = s_ff.be;
   assign BUS.wdata = s_ff.wdata;
   assign USR_READY = s_ff.ready;
   assign USR_DONE = s_ff.done;
   assign USR_RDATA = s_ff.rdata;

   // sequencer
   always_comb begin
      nxt_s = s_ff;
      nxt_s.wr = 1'b0;
      nxt_s.rd = 1'b0;
      nxt_s.done = 1'b0;
      wd = USR_WDATA;
      // reserved bits of run and sync always go out as zero
      if (USR_ADDR[7:1] == tmr_pkg::ADDR_GLOBAL[7:1]) begin
         wd = USR_WDATA & {tmr_pkg::RUN_MASK, tmr_pkg::SYNC_MASK};
      end
      unique case (s_ff.st)
         tmr_pkg::HS_IDLE: begin
            if (USR_REQ) begin
               nxt_s.st = tmr_pkg::HS_WAIT;
               nxt_s.ready = 1'b0;
               nxt_s.addr = USR_ADDR;
               nxt_s.wr = USR_WRITE;
               nxt_s.rd = !USR_WRITE;
               nxt_s.wdata = wd;
               // counters and general registers only ever see whole words
               nxt_s.be = tmr_pkg::tmr_is_word_reg(USR_ADDR) ? 2'b11 : USR_BE;
            end
         end
         tmr_pkg::HS_WAIT: begin
            if (BUS.ack) begin
               nxt_s.st = tmr_pkg::HS_IDLE;
               nxt_s.ready = 1'b1;
               nxt_s.done = 1'b1;
               if (!s_ff.wr) nxt_s.rdata = BUS.rdata;
            end
         end
         default: begin
            nxt_s.st = tmr_pkg::HS_IDLE;
            nxt_s.ready = 1'b1;
         end
      endcase
      // the strobe is a one-cycle pulse, cleared after its cycle
      if (s_ff.st == tmr_pkg::HS_WAIT) begin
         nxt_s.wr = 1'b0;
         nxt_s.rd = 1'b0;
      end
   end

   // state register with synchronous reset
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         s_ff <= '0;
         s_ff.st <= tmr_pkg::HS_IDLE;
         s_ff.ready <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule
`default_nettype wire

// ### tb/tmr_bus_monitor.sv
// bus-level assertions on the register bus between the two timer ends
`timescale 1ns/1ps
`default_nettype none
module tmr_bus_monitor (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic [7:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [1:0] be,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic ack
);
   // counter and general register window, whole words only
   logic word_hit;
   assign word_hit = (addr[7:6] == 2'b00) && (addr[5:4] != 2'b11) && (addr[3:1] >= 3'h2) &&
                     (addr[3:1] <= 3'h6);
   // one clock domain, so one default clock and reset
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   ack_after_strobe_a: assert property ((wr || rd) |=> ack)
      else $error("strobe not answered one cycle later");
   ack_single_a: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   ack_has_cause_a: assert property (ack |-> $past(wr || rd))
      else $error("ack without a strobe");
   strobe_gap_a: assert property ((wr || rd) |=> !(wr || rd) [*2])
      else $error("strobes closer than three cycles");
   word_lanes_a: assert property ((wr || rd) && word_hit |-> be == 2'b11)
      else $error("byte lanes on a word register");
   run_reserved_a: assert property (ack && $past(rd) && (($past(addr) | 8'h01) == 8'h31)
      |-> (rdata[15:11] == 5'h00) && (rdata[7:3] == 5'h00))
      else $error("reserved run or sync bits read nonzero");
   flags_reserved_a: assert property (ack && $past(rd) && ((($past(addr) | 8'h01) == 8'h13) ||
      (($past(addr) | 8'h01) == 8'h23)) |-> rdata[3:2] == 2'b00)
      else $error("channel 1 or 2 flag c or d read nonzero");
   rd_wr_excl_a: assert property (wr |-> !rd)
      else $error("read and write strobe together");
   rdata_hold_a: assert property (!rd |=> $stable(rdata))
      else $error("read data moved without a read");
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench: host end and device end joined on one bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; $display("ERROR %0t: got %h exp %h", $time, got, exp); end end
module tb_top;
   // table row: optional write, then word read-back
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
      logic [15:0] exp;
   } tmr_row_type;
   logic core_clk, rst_n, count_tick;
   logic [2:0][1:0] pin_in, pin_out, pin_oe;
   logic [2:0] irq;
   logic usr_req, usr_write, usr_ready, usr_done;
   logic [7:0] usr_addr;
   logic [1:0] usr_be;
   logic [15:0] usr_wdata, usr_rdata, rd_val, tmp, cnt_a, cnt_b;
   int err_count = 0;
   int checks_done = 0;
   tmr_row_type rows [11];
   tmr_bus_if bus_if ();
   tmr_core_dev u_tmr_core_dev (.CORE_CLK(core_clk), .RST_N(rst_n), .COUNT_TICK(count_tick),
      .PIN_IN(pin_in), .BUS(bus_if), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .IRQ(irq));
   tmr_core_host u_tmr_core_host (.CORE_CLK(core_clk), .RST_N(rst_n), .USR_REQ(usr_req),
      .USR_WRITE(usr_write), .USR_ADDR(usr_addr), .USR_BE(usr_be), .USR_WDATA(usr_wdata),
      .USR_READY(usr_ready), .USR_DONE(usr_done), .USR_RDATA(usr_rdata), .BUS(bus_if));
   tmr_bus_monitor u_tmr_bus_monitor (.CORE_CLK(core_clk), .RST_N(rst_n), .addr(bus_if.addr),
      .wr(bus_if.wr), .rd(bus_if.rd), .be(bus_if.be), .wdata(bus_if.wdata),
      .rdata(bus_if.rdata), .ack(bus_if.ack));
   // 125 mhz clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // prints counts and verdict, sole end of the run
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one user request; done sampled at negedge to stay clear of the update edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [1:0] b,
                       input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      usr_req <= 1'b1;
      usr_write <= w;
      usr_addr <= a;
      usr_be <= b;
      usr_wdata <= d;
      @(posedge core_clk);
      usr_req <= 1'b0;
      @(negedge core_clk);
      while (usr_done !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 20) begin
         err_count++;
         $display("ERROR %0t: no done from host", $time);
      end
      q = usr_rdata;
   endtask
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      err_count++;
      $display("ERROR %0t: watchdog expired", $time);
      close_out();
   end
   // main sequence
   initial begin
      usr_req = 1'b0;
      usr_write = 1'b0;
      usr_addr = 8'h00;
      usr_be = 2'h0;
      usr_wdata = 16'h0000;
      count_tick = 1'b0;
      pin_in = '0;
      rst_n = 1'b0;
      rows = '{'{1'b0, 8'h06, 2'h3, 16'h0000, 16'hffff}, '{1'b0, 8'h0c, 2'h3, 16'h0000, 16'hffff},
               '{1'b0, 8'h04, 2'h3, 16'h0000, 16'h0000}, '{1'b0, 8'h24, 2'h3, 16'h0000, 16'h0000},
               '{1'b0, 8'h30, 2'h3, 16'h0000, 16'h0000}, '{1'b0, 8'h22, 2'h3, 16'h0000, 16'h0000},
               '{1'b1, 8'h16, 2'h3, 16'h1234, 16'h1234}, '{1'b1, 8'h2a, 2'h3, 16'h5555, 16'h0000},
               '{1'b1, 8'h00, 2'h2, 16'h5a00, 16'h0a00}, '{1'b1, 8'h00, 2'h1, 16'h0077, 16'h0a77},
               '{1'b1, 8'h00, 2'h3, 16'h0000, 16'h0000}};
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      // reset values, unmapped slot, byte lanes of byte registers
      foreach (rows[i]) begin
         if (rows[i].wr === 1'b1) xfer(1'b1, rows[i].addr, rows[i].be, rows[i].wdata, tmp);
         xfer(1'b0, rows[i].addr, 2'h3, 16'h0000, rd_val);
         `CHK(rd_val, rows[i].exp)
      end
      $display("table test done");
      // channel 1 compare b, then halt and flag clearing
      xfer(1'b1, 8'h18, 2'h3, 16'h0005, tmp);
      @(posedge core_clk);
      count_tick <= 1'b1;
      xfer(1'b1, 8'h30, 2'h2, 16'h0200, tmp);
      repeat (20) @(posedge core_clk);
      xfer(1'b1, 8'h30, 2'h2, 16'h0000, tmp);
      `CHK(pin_out[1], 2'b10)
      xfer(1'b0, 8'h14, 2'h3, 16'h0000, cnt_a);
      xfer(1'b0, 8'h14, 2'h3, 16'h0000, cnt_b);
      `CHK(cnt_a, cnt_b)
      `CHK(cnt_a > 16'h0005, 1'b1)
      // zero write before any read must not clear the flag
      xfer(1'b1, 8'h12, 2'h1, 16'h0000, tmp);
      xfer(1'b0, 8'h12, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, 16'h0002)
      xfer(1'b1, 8'h12, 2'h1, 16'h0002, tmp);
      xfer(1'b0, 8'h12, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, 16'h0002)
      xfer(1'b1, 8'h12, 2'h1, 16'h0000, tmp);
      xfer(1'b0, 8'h12, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, 16'h0000)
      xfer(1'b1, 8'h10, 2'h1, 16'h0030, tmp);
      `CHK({pin_out[1], pin_oe[1]}, 4'hf)
      $display("channel 1 test done");
      // channel 0: compare d, capture a and c from pin a, interrupt enable
      xfer(1'b1, 8'h0c, 2'h3, 16'h0003, tmp);
      xfer(1'b1, 8'h00, 2'h1, 16'h0005, tmp);
      xfer(1'b1, 8'h30, 2'h2, 16'h0100, tmp);
      repeat (10) @(posedge core_clk);
      pin_in[0][0] <= 1'b1;
      repeat (3) @(posedge core_clk);
      xfer(1'b1, 8'h30, 2'h2, 16'h0000, tmp);
      xfer(1'b0, 8'h02, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, 16'h000d)
      xfer(1'b0, 8'h06, 2'h3, 16'h0000, rd_val);
      xfer(1'b0, 8'h04, 2'h3, 16'h0000, cnt_a);
      `CHK((rd_val !== 16'hffff) && (rd_val < cnt_a), 1'b1)
      xfer(1'b0, 8'h0a, 2'h3, 16'h0000, cnt_b);
      `CHK(cnt_b, rd_val)
      `CHK(irq[0], 1'b0)
      xfer(1'b1, 8'h02, 2'h2, 16'h0800, tmp);
      `CHK(irq[0], 1'b1)
      $display("channel 0 test done");
      // synchronized preset reaches channel 1 only
      xfer(1'b1, 8'h30, 2'h1, 16'h0003, tmp);
      xfer(1'b1, 8'h04, 2'h3, 16'h0abc, tmp);
      xfer(1'b0, 8'h14, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, 16'h0abc)
      xfer(1'b0, 8'h24, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, 16'h0000)
      $display("sync test done");
      // channel 0 buffer: a capture pushes the old a value into c
      xfer(1'b1, 8'h00, 2'h2, 16'h0400, tmp);
      @(posedge core_clk);
      pin_in[0][0] <= 1'b0;
      repeat (2) @(posedge core_clk);
      pin_in[0][0] <= 1'b1;
      repeat (2) @(posedge core_clk);
      xfer(1'b0, 8'h0a, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, cnt_b)
      xfer(1'b0, 8'h06, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, 16'h0abc)
      $display("buffer test done");
      // second reset in mid-run clears state again
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      xfer(1'b0, 8'h04, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, 16'h0000)
      xfer(1'b0, 8'h02, 2'h3, 16'h0000, rd_val);
      `CHK(rd_val, 16'h0000)
      `CHK(irq, 3'h0)
      $display("reset test done");
      close_out();
   end
endmodule
`default_nettype wire
